// ===== rtl/fsl_pkg.sv
// constants, encodings and register map of the fieldbus slave status indicators
package fsl_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ = 40_000_000;
  localparam int FLICKER_MS = 50;
  localparam int FLASH_ON_MS = 200;
  localparam int BLINK_OFF_MS = 200;
  localparam int FLASH_GAP_MS = 1000;
  localparam int MS_PER_S = 1000;
  // one pattern unit is one flicker half period
  localparam int UNIT_CYCLES = FLICKER_MS * (CLK_HZ / MS_PER_S);
  localparam int TICK_W = 21;
  localparam int PH_W = 6;
  localparam logic [PH_W-1:0] PH_ZERO = 6'h00;
  localparam logic [PH_W-1:0] PH_ONE = 6'h01;
  localparam logic [PH_W-1:0] U_ON = PH_W'(FLASH_ON_MS / FLICKER_MS);
  localparam logic [PH_W-1:0] U_BLINK_PER = PH_W'((FLASH_ON_MS + BLINK_OFF_MS) / FLICKER_MS);
  localparam logic [PH_W-1:0] U_SINGLE_PER = PH_W'((FLASH_ON_MS + FLASH_GAP_MS) / FLICKER_MS);
  localparam logic [PH_W-1:0] U_DBL_ON2 = PH_W'((2 * FLASH_ON_MS) / FLICKER_MS);
  localparam logic [PH_W-1:0] U_DBL_OFF2 = PH_W'((3 * FLASH_ON_MS) / FLICKER_MS);
  localparam logic [PH_W-1:0] U_DOUBLE_PER = PH_W'((3 * FLASH_ON_MS + FLASH_GAP_MS) / FLICKER_MS);

  // ****************************************
  // slave state codes
  // ****************************************
  localparam int ST_W = 4;
  localparam logic [ST_W-1:0] AL_INIT = 4'h1;
  localparam logic [ST_W-1:0] AL_PREOP = 4'h2;
  localparam logic [ST_W-1:0] AL_BOOT = 4'h3;
  localparam logic [ST_W-1:0] AL_SAFEOP = 4'h4;
  localparam logic [ST_W-1:0] AL_OP = 4'h8;

  // ****************************************
  // indicator patterns, one-hot
  // ****************************************
  typedef enum logic [5:0] {
    PAT_OFF = 6'h01,
    PAT_ON = 6'h02,
    PAT_FLICKER = 6'h04,
    PAT_BLINK = 6'h08,
    PAT_SINGLE = 6'h10,
    PAT_DOUBLE = 6'h20
  } fsl_pat_e;

  // ****************************************
  // register map
  // ****************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] REG_STATUS = 12'h004;
  localparam logic [ADDR_W-1:0] REG_INT_STATUS = 12'h008;
  localparam logic [ADDR_W-1:0] REG_INT_MASK = 12'h00c;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RESET = 1'h1;
  localparam int EV_W = 3;
  localparam int EV_ERR_SET = 0;
  localparam int EV_RUN_CHG = 1;
  localparam int EV_ERR_CLR = 2;
  localparam logic [EV_W-1:0] EV_ZERO = 3'h0;
  localparam logic [EV_W-1:0] MASK_RESET = 3'h0;
  localparam int STS_RUN_LSB = 0;
  localparam int STS_ERR_LSB = 8;
  localparam int STS_RUN_LED = 16;
  localparam int STS_ERR_LED = 17;
  localparam int STS_FITTED = 18;

endpackage

// ===== rtl/fsl_sync.sv
// three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module fsl_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // asynchronous input and its clean copy
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  import fsl_pkg::*;

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] next_sync;

  // accept a bit only when the two settled stages agree
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_sync[i] = (s2[i] == s3[i]) ? s3[i] : sync_out[i];
    end
  end

  // s1 feeds only s2, so metastability stays in the chain
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      sync_out <= '0;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      sync_out <= next_sync;
    end
  end
endmodule // fsl_sync
`default_nettype wire

// ===== rtl/fsl_tick.sv
// free-running divider giving a one-cycle tick every PERIOD clocks
`timescale 1ns/1ps
`default_nettype none
module fsl_tick #(
  parameter int PERIOD = 2
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // tick
  output logic tick_out
);
  import fsl_pkg::*;

  localparam logic [TICK_W-1:0] LAST = TICK_W'(PERIOD - 1);
  logic [TICK_W-1:0] count;
  logic [TICK_W-1:0] next_count;
  logic next_tick;

  // wrap at the last count and flag it
  always_comb begin
    next_tick = (count == LAST);
    next_count = next_tick ? '0 : count + 1'b1;
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count <= '0;
      tick_out <= 1'b0;
    end else begin
      count <= next_count;
      tick_out <= next_tick;
    end
  end
endmodule // fsl_tick
`default_nettype wire

// ===== rtl/fsl_leds.sv
// run and error indicator driver for the fieldbus slave, with apb registers
`timescale 1ns/1ps
`default_nettype none
module fsl_leds
  import fsl_pkg::*;
#(
  parameter int UNIT_CYC = UNIT_CYCLES
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [DATA_W-1:0] pwdata_in,
  output logic [DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // option module presence pin
  input wire logic option_fitted_in,
  // slave state machine status
  input wire logic [ST_W-1:0] slave_state_in,
  input wire logic booting_in,
  input wire logic al_err_ind_in,
  input wire logic app_fail_in,
  input wire logic wdog_timeout_in,
  input wire logic local_error_in,
  input wire logic config_error_in,
  // normal controller led meaning
  input wire logic ctl_run_led_in,
  input wire logic ctl_err_led_in,
  // indicators and interrupt
  output logic run_led_out,
  output logic err_led_out,
  output logic irq_out
);

  // ****************************************
  // timebase and pin input
  // ****************************************
  logic unit_tick;
  logic fitted;

  fsl_tick #(
    .PERIOD(UNIT_CYC)
  ) u_tick (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .tick_out(unit_tick)
  );

  fsl_sync #(
    .WIDTH(1)
  ) u_fit_sync (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .async_in(option_fitted_in),
    .sync_out(fitted)
  );

  // ****************************************
  // pattern selection
  // ****************************************
  fsl_pat_e run_pat;
  fsl_pat_e err_pat;
  fsl_pat_e next_run_pat;
  fsl_pat_e next_err_pat;
  logic ctrl_en;
  logic active;

  assign active = fitted & ctrl_en;

  // run pattern follows the slave state, boot indications first
  always_comb begin
    if (booting_in || slave_state_in == AL_BOOT) begin
      next_run_pat = PAT_FLICKER;
    end else if (slave_state_in == AL_OP) begin
      next_run_pat = PAT_ON;
    end else if (slave_state_in == AL_SAFEOP) begin
      next_run_pat = PAT_SINGLE;
    end else if (slave_state_in == AL_PREOP) begin
      next_run_pat = PAT_BLINK;
    end else begin
      next_run_pat = PAT_OFF;
    end
  end

  // error pattern by severity; only the six legal patterns exist
  always_comb begin
    if (app_fail_in) begin
      next_err_pat = PAT_ON;
    end else if (slave_state_in == AL_INIT && al_err_ind_in) begin
      next_err_pat = PAT_FLICKER;
    end else if (wdog_timeout_in) begin
      next_err_pat = PAT_DOUBLE;
    end else if (local_error_in && al_err_ind_in) begin
      next_err_pat = PAT_SINGLE;
    end else if (config_error_in) begin
      next_err_pat = PAT_BLINK;
    end else begin
      next_err_pat = PAT_OFF;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      run_pat <= PAT_FLICKER;
      err_pat <= PAT_OFF;
    end else begin
      run_pat <= next_run_pat;
      err_pat <= next_err_pat;
    end
  end

  // ****************************************
  // pattern phase counters
  // ****************************************
  logic flick;
  logic [PH_W-1:0] blink_ph;
  logic [PH_W-1:0] single_ph;
  logic [PH_W-1:0] double_ph;
  logic next_flick;
  logic [PH_W-1:0] next_blink_ph;
  logic [PH_W-1:0] next_single_ph;
  logic [PH_W-1:0] next_double_ph;

  // free running, so both leds in one pattern stay in step
  always_comb begin
    next_flick = flick;
    next_blink_ph = blink_ph;
    next_single_ph = single_ph;
    next_double_ph = double_ph;
    if (unit_tick) begin
      next_flick = ~flick;
      next_blink_ph = (blink_ph == U_BLINK_PER - PH_ONE) ? PH_ZERO : blink_ph + PH_ONE;
      next_single_ph = (single_ph == U_SINGLE_PER - PH_ONE) ? PH_ZERO : single_ph + PH_ONE;
      next_double_ph = (double_ph == U_DOUBLE_PER - PH_ONE) ? PH_ZERO : double_ph + PH_ONE;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      flick <= 1'b0;
      blink_ph <= PH_ZERO;
      single_ph <= PH_ZERO;
      double_ph <= PH_ZERO;
    end else begin
      flick <= next_flick;
      blink_ph <= next_blink_ph;
      single_ph <= next_single_ph;
      double_ph <= next_double_ph;
    end
  end

  // ****************************************
  // led drive
  // ****************************************
  function automatic logic pat_level(input fsl_pat_e pat, input logic fl,
                                     input logic [PH_W-1:0] bp, input logic [PH_W-1:0] sp,
                                     input logic [PH_W-1:0] dp);
    logic lv;
    lv = 1'b0;
    case (pat)
      PAT_ON: lv = 1'b1;
      PAT_FLICKER: lv = fl;
      PAT_BLINK: lv = (bp < U_ON);
      PAT_SINGLE: lv = (sp < U_ON);
      PAT_DOUBLE: lv = (dp < U_ON) || (dp >= U_DBL_ON2 && dp < U_DBL_OFF2);
      default: lv = 1'b0;
    endcase
    return lv;
  endfunction

  logic next_run_led;
  logic next_err_led;

  // without the option the controller keeps its own led meaning
  always_comb begin
    if (active) begin
      next_run_led = pat_level(run_pat, flick, blink_ph, single_ph, double_ph);
      next_err_led = pat_level(err_pat, flick, blink_ph, single_ph, double_ph);
    end else begin
      next_run_led = ctl_run_led_in;
      next_err_led = ctl_err_led_in;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      run_led_out <= 1'b0;
      err_led_out <= 1'b0;
    end else begin
      run_led_out <= next_run_led;
      err_led_out <= next_err_led;
    end
  end

  // ****************************************
  // apb slave and registers
  // ****************************************
  logic [EV_W-1:0] int_sts;
  logic [EV_W-1:0] int_mask;
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] next_int_sts;
  logic [EV_W-1:0] next_int_mask;
  logic next_ctrl_en;
  logic next_irq;
  logic next_pready;
  logic next_pslverr;
  logic [DATA_W-1:0] next_prdata;
  logic done;
  logic rd_clr;

  // one wait state keeps every bus output on a flip-flop
  assign done = psel_in & penable_in & pready_out;

  // events from pattern changes
  always_comb begin
    events = EV_ZERO;
    events[EV_ERR_SET] = (next_err_pat != PAT_OFF) && (err_pat == PAT_OFF);
    events[EV_RUN_CHG] = (next_run_pat != run_pat);
    events[EV_ERR_CLR] = (next_err_pat == PAT_OFF) && (err_pat != PAT_OFF);
  end

  // decode, read data, writes and read-to-clear; a new event beats the clear
  always_comb begin
    next_pready = psel_in & penable_in & ~pready_out;
    next_pslverr = 1'b0;
    next_prdata = DATA_ZERO;
    next_ctrl_en = ctrl_en;
    next_int_mask = int_mask;
    rd_clr = 1'b0;
    if (paddr_in == REG_CTRL) begin
      next_prdata[CTRL_EN_BIT] = ctrl_en;
      if (done && pwrite_in) begin
        next_ctrl_en = pwdata_in[CTRL_EN_BIT];
      end
    end else if (paddr_in == REG_STATUS) begin
      next_prdata[STS_RUN_LSB +: 6] = run_pat;
      next_prdata[STS_ERR_LSB +: 6] = err_pat;
      next_prdata[STS_RUN_LED] = run_led_out;
      next_prdata[STS_ERR_LED] = err_led_out;
      next_prdata[STS_FITTED] = fitted;
    end else if (paddr_in == REG_INT_STATUS) begin
      next_prdata[EV_W-1:0] = int_sts;
      rd_clr = done && !pwrite_in;
    end else if (paddr_in == REG_INT_MASK) begin
      next_prdata[EV_W-1:0] = int_mask;
      if (done && pwrite_in) begin
        next_int_mask = pwdata_in[EV_W-1:0];
      end
    end else begin
      next_pslverr = next_pready;
    end
    if (!next_pready || pwrite_in) begin
      next_prdata = DATA_ZERO;
    end
    // clear only the bits the reader was shown, so an event landing in the wait state survives
    next_int_sts = (int_sts & ~(rd_clr ? prdata_out[EV_W-1:0] : EV_ZERO)) | events;
    next_irq = |(next_int_sts & next_int_mask);
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_en <= CTRL_EN_RESET;
      int_mask <= MASK_RESET;
      int_sts <= EV_ZERO;
      irq_out <= 1'b0;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= DATA_ZERO;
    end else begin
      ctrl_en <= next_ctrl_en;
      int_mask <= next_int_mask;
      int_sts <= next_int_sts;
      irq_out <= next_irq;
      pready_out <= next_pready;
      pslverr_out <= next_pslverr;
      prdata_out <= next_prdata;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_tick_flicker;
    unit_tick && active && run_pat == PAT_FLICKER && next_run_pat == PAT_FLICKER;
  endsequence

  sequence s_led_toggled;
    ##2 run_led_out != $past(run_led_out);
  endsequence

  a_pass_through: assert property (!active |=> run_led_out == $past(ctl_run_led_in))
    else $error("run led does not follow controller led");
  a_run_op_on: assert property (
      active && run_pat == PAT_ON && next_run_pat == PAT_ON |=> run_led_out)
    else $error("run led not on in op");
  a_run_init_off: assert property (
      slave_state_in == AL_INIT && !booting_in |=> run_pat == PAT_OFF)
    else $error("run pattern not off in init");
  a_run_booting: assert property (booting_in |=> run_pat == PAT_FLICKER)
    else $error("run pattern not flicker while booting");
  a_run_bootstrap: assert property (slave_state_in == AL_BOOT |=> run_pat == PAT_FLICKER)
    else $error("run pattern not flicker in bootstrap");
  a_err_fail_on: assert property (app_fail_in |=> err_pat == PAT_ON)
    else $error("error pattern not on after failure");
  a_err_wdog_dbl: assert property (
      wdog_timeout_in && !app_fail_in && !(slave_state_in == AL_INIT && al_err_ind_in)
      |=> err_pat == PAT_DOUBLE)
    else $error("error pattern not double flash on watchdog");
  a_err_local_sgl: assert property (
      local_error_in && al_err_ind_in && !app_fail_in && !wdog_timeout_in
      && slave_state_in != AL_INIT |=> err_pat == PAT_SINGLE)
    else $error("error pattern not single flash on local error");
  a_err_cfg_blink: assert property (
      config_error_in && !app_fail_in && !wdog_timeout_in && !al_err_ind_in
      |=> err_pat == PAT_BLINK)
    else $error("error pattern not blink on config error");
  a_err_boot_flick: assert property (
      slave_state_in == AL_INIT && al_err_ind_in && !app_fail_in
      |=> err_pat == PAT_FLICKER)
    else $error("error pattern not flicker on booting error");
  a_err_clear_off: assert property (
      active && !app_fail_in && !wdog_timeout_in && !config_error_in && !al_err_ind_in
      ##1 active |=> !err_led_out)
    else $error("error led lit with no error");
  a_err_no_reserved: assert property ($onehot(err_pat))
    else $error("error pattern outside legal set");
  a_flicker_rate: assert property (s_tick_flicker |-> s_led_toggled)
    else $error("flicker did not toggle on unit tick");
  a_dbl_period: assert property (
      unit_tick && double_ph == U_DOUBLE_PER - PH_ONE |=> double_ph == PH_ZERO)
    else $error("double flash period wrong");

endmodule // fsl_leds
`default_nettype wire

// ===== tb/fsl_slave_model.sv
// slave state machine stand-in driving the status inputs of the indicator block
`timescale 1ns/1ps
`default_nettype none
module fsl_slave_model
  import fsl_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // case picked by the bench
  input wire logic [2:0] case_in,
  // status towards the indicators: booting, al_err, app_fail, wdog, local, config
  output logic [ST_W-1:0] state_out,
  output logic [5:0] flags_out
);
  // ****************************************
  // status table
  // ****************************************
  // registered so that inputs move only just after an edge, as the real machine does
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      {state_out, flags_out} <= {AL_INIT, 6'h20};
    end else begin
      case (case_in)
        3'h0: {state_out, flags_out} <= {AL_INIT, 6'h28}; // booting, critical failure
        3'h1: {state_out, flags_out} <= {AL_INIT, 6'h10}; // init with indicator bit
        3'h2: {state_out, flags_out} <= {AL_PREOP, 6'h04};
        3'h3: {state_out, flags_out} <= {AL_SAFEOP, 6'h12};
        3'h4: {state_out, flags_out} <= {AL_OP, 6'h01};
        3'h5: {state_out, flags_out} <= {AL_BOOT, 6'h00};
        3'h6: {state_out, flags_out} <= {AL_PREOP, 6'h0d}; // several errors at once
        default: {state_out, flags_out} <= {AL_INIT, 6'h00};
      endcase
    end
  end
endmodule // fsl_slave_model
`default_nettype wire

// ===== tb/fsl_leds_tb.sv
// self-checking bench for the run and error indicator driver
`timescale 1ns/1ps
`default_nettype none
module fsl_leds_tb;
  import fsl_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  // small unit keeps every pattern period short; window of 384 spans whole periods
  localparam int UNIT = 4;
  localparam int WIN = 384;
  logic clock_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [DATA_W-1:0] pwdata = 32'h0000_0000;
  logic [DATA_W-1:0] prdata;
  logic pready, pslverr, fitted = 1'b1, ctl_run = 1'b0, ctl_err = 1'b0;
  logic run_led, err_led, irq;
  logic [2:0] case_sel = 3'h7;
  logic [ST_W-1:0] state;
  logic [5:0] flags;
  logic [DATA_W-1:0] rd;
  logic er;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  // ****************************************
  // clock, timeout, instances
  // ****************************************
  always #12.5 clock_in = ~clock_in;
  // ceiling well above the roughly 3000 cycles the tests need
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  fsl_slave_model sm (.clock_in(clock_in), .rst_b_in(rst_b_in), .case_in(case_sel),
    .state_out(state), .flags_out(flags));
  fsl_leds #(.UNIT_CYC(UNIT)) uut (.clock_in(clock_in), .rst_b_in(rst_b_in),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .option_fitted_in(fitted), .slave_state_in(state), .booting_in(flags[5]),
    .al_err_ind_in(flags[4]), .app_fail_in(flags[3]), .wdog_timeout_in(flags[2]),
    .local_error_in(flags[1]), .config_error_in(flags[0]), .ctl_run_led_in(ctl_run),
    .ctl_err_led_in(ctl_err), .run_led_out(run_led), .err_led_out(err_led), .irq_out(irq));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer; request held until pready is seen, released at that edge
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clock_in);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    pen <= 1'b1;
    // pready and the answer are taken at the rising edge that completes the access
    do begin
      @(posedge clock_in);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  // lit cycles and rising edges of both leds over one window
  task automatic measure(output int rl, output int rr, output int el, output int erx);
    logic pr, pe;
    rl = 0; rr = 0; el = 0; erx = 0;
    @(negedge clock_in);
    pr = run_led;
    pe = err_led;
    repeat (WIN) begin
      @(negedge clock_in);
      rl += (run_led === 1'b1);
      el += (err_led === 1'b1);
      rr += (run_led === 1'b1 && pr === 1'b0);
      erx += (err_led === 1'b1 && pe === 1'b0);
      pr = run_led;
      pe = err_led;
    end
  endtask
  // expected lit count and edge count of a pattern over the window
  function automatic logic [31:0] exp_lit(input fsl_pat_e p);
    case (p)
      PAT_ON: return 32'h0000_0180;
      PAT_FLICKER, PAT_BLINK: return 32'h0000_00c0;
      PAT_SINGLE: return 32'h0000_0040;
      PAT_DOUBLE: return 32'h0000_0060;
      default: return 32'h0000_0000;
    endcase
  endfunction
  function automatic logic [31:0] exp_rise(input fsl_pat_e p);
    case (p)
      PAT_FLICKER: return 32'h0000_0030;
      PAT_BLINK: return 32'h0000_000c;
      PAT_SINGLE: return 32'h0000_0004;
      PAT_DOUBLE: return 32'h0000_0006;
      default: return 32'h0000_0000;
    endcase
  endfunction
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    apb(1'b0, REG_CTRL, DATA_ZERO);
    chk("ctrl reset", 32'h0000_0001, rd);
    chk("ctrl no err", 32'h0000_0000, {31'h0, er});
    apb(1'b0, REG_STATUS, DATA_ZERO);
    chk("status fitted", 32'h0000_0001, {31'h0, rd[STS_FITTED]});
    apb(1'b0, REG_INT_MASK, DATA_ZERO);
    chk("mask reset", 32'h0000_0000, rd);
    apb(1'b0, 12'h010, DATA_ZERO);
    chk("unmapped err", 32'h0000_0001, {31'h0, er});
    chk("unmapped data", 32'h0000_0000, rd);
    $display("regs done");
  endtask
  task automatic t_patterns();
    fsl_pat_e rp[7] = '{PAT_FLICKER, PAT_OFF, PAT_BLINK, PAT_SINGLE, PAT_ON, PAT_FLICKER,
      PAT_BLINK};
    fsl_pat_e ep[7] = '{PAT_ON, PAT_FLICKER, PAT_DOUBLE, PAT_SINGLE, PAT_BLINK, PAT_OFF,
      PAT_ON};
    int rl, rr, el, erx;
    for (int i = 0; i < 7; i++) begin
      @(posedge clock_in);
      case_sel <= 3'(i);
      wait_cyc(8);
      apb(1'b0, REG_STATUS, DATA_ZERO);
      chk("run pattern", {26'h0, rp[i]}, {26'h0, rd[5:0]});
      chk("err pattern", {26'h0, ep[i]}, {26'h0, rd[13:8]});
      measure(rl, rr, el, erx);
      chk("run lit", exp_lit(rp[i]), 32'(rl));
      chk("run edges", exp_rise(rp[i]), 32'(rr));
      chk("err lit", exp_lit(ep[i]), 32'(el));
      chk("err edges", exp_rise(ep[i]), 32'(erx));
    end
    $display("patterns done");
  endtask
  task automatic t_passthru();
    apb(1'b1, REG_CTRL, DATA_ZERO);
    ctl_run <= 1'b1;
    wait_cyc(4);
    chk("pass run", 32'h0000_0001, {31'h0, run_led});
    chk("pass err", 32'h0000_0000, {31'h0, err_led});
    apb(1'b1, REG_CTRL, 32'h0000_0001);
    // error pattern is steady on here, so a dark error led proves the pass-through
    fitted <= 1'b0;
    ctl_run <= 1'b1;
    ctl_err <= 1'b0;
    wait_cyc(10);
    chk("unfitted run", 32'h0000_0001, {31'h0, run_led});
    chk("unfitted err", 32'h0000_0000, {31'h0, err_led});
    fitted <= 1'b1;
    wait_cyc(10);
    $display("passthrough done");
  endtask
  task automatic t_irq();
    case_sel <= 3'h5;
    wait_cyc(8);
    apb(1'b0, REG_INT_STATUS, DATA_ZERO);
    apb(1'b1, REG_INT_MASK, 32'h0000_0001);
    chk("irq idle", 32'h0000_0000, {31'h0, irq});
    case_sel <= 3'h2;
    wait_cyc(6);
    chk("irq raised", 32'h0000_0001, {31'h0, irq});
    apb(1'b0, REG_INT_STATUS, DATA_ZERO);
    chk("err raised", 32'h0000_0001, {31'h0, rd[0]});
    wait_cyc(3);
    chk("irq cleared", 32'h0000_0000, {31'h0, irq});
    apb(1'b1, REG_INT_MASK, 32'h0000_0004);
    apb(1'b0, REG_INT_MASK, DATA_ZERO);
    chk("mask readback", 32'h0000_0004, rd);
    case_sel <= 3'h5;
    wait_cyc(6);
    chk("irq err gone", 32'h0000_0001, {31'h0, irq});
    apb(1'b0, REG_INT_STATUS, DATA_ZERO);
    wait_cyc(3);
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    $display("interrupt done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    wait_cyc(2);
    rst_b_in <= 1'b1;
    wait_cyc(10);
    t_regs();
    t_patterns();
    t_passthru();
    t_irq();
    tally_and_finish();
  end
endmodule // fsl_leds_tb
`default_nettype wire
